/* File: core/iosc_pkg.sv */
// Purpose: shared constants and types of the interrupt option and sleep control block
// Assumes: APB3 slave, 32-bit data, register index times four gives the byte address
// Notes: register indices are kept as printed, byte addresses derive from them
package iosc_pkg;

    // Register indices and byte addresses
    localparam logic [11:0] IOSC_OPT_IDX = 12'h0C8;
    localparam logic [11:0] IOSC_POL_IDX = 12'h0DA;
    localparam logic [11:0] IOSC_STAT_IDX = 12'h0DB;
    localparam logic [11:0] IOSC_OPT_ADDR = 12'(IOSC_OPT_IDX * 4);
    localparam logic [11:0] IOSC_POL_ADDR = 12'(IOSC_POL_IDX * 4);
    localparam logic [11:0] IOSC_STAT_ADDR = 12'(IOSC_STAT_IDX * 4);

    // Option register fields
    localparam int unsigned IOSC_OPT_LES_BIT = 6;
    localparam int unsigned IOSC_OPT_ESB_BIT = 5;
    localparam int unsigned IOSC_OPT_GEN_BIT = 4;
    localparam logic [7:0] IOSC_OPT_USED = 8'h70;
    localparam logic [7:0] IOSC_OPT_RST = 8'h00;

    // Polarity register fields
    localparam int unsigned IOSC_POL_D_BIT = 3;
    localparam int unsigned IOSC_POL_A_BIT = 1;
    localparam int unsigned IOSC_POL_B_BIT = 0;
    localparam logic [7:0] IOSC_POL_USED = 8'h0B;
    localparam logic [7:0] IOSC_POL_RST = 8'h00;

    // Request line positions toward the core
    localparam int unsigned IOSC_SRC_NMI = 0;
    localparam int unsigned IOSC_SRC_1 = 1;
    localparam int unsigned IOSC_SRC_2 = 2;
    localparam int unsigned IOSC_SRC_3 = 3;
    localparam int unsigned IOSC_SRC_4 = 4;

    // Default oscillator settling count, reference clock cycles
    localparam int unsigned IOSC_STAB_CYCLES_DEF = 2048;

    // Sleep sequencer states
    typedef enum logic [3:0] {
        IOSC_RUN = 4'b0001,
        IOSC_WAIT = 4'b0010,
        IOSC_STOP = 4'b0100,
        IOSC_STAB = 4'b1000
    } iosc_sleep_t;

    // APB request from the master
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } iosc_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } iosc_apb_rsp_t;

    // Peripheral event flags, same clock
    typedef struct packed {
        logic timer_overflow_flag;
        logic conversion_end;
        logic serial_byte_received;
        logic serial_byte_sent;
        logic reload_timer_overflow;
        logic reload_timer_compare_hit;
        logic reload_timer_input_edge;
    } iosc_evt_t;

    // Peripheral mask bits, same order as the events
    typedef struct packed {
        logic timer_irq_mask;
        logic converter_irq_mask;
        logic serial_rx_irq_mask;
        logic serial_tx_irq_mask;
        logic reload_overflow_irq_mask;
        logic reload_compare_irq_mask;
        logic reload_edge_irq_mask;
    } iosc_mask_t;

    // Core side strobes
    typedef struct packed {
        logic wait_exec;
        logic stop_exec;
        logic watchdog_active;
        logic [4:0] service_ack;
    } iosc_core_t;

endpackage

/* File: core/iosc_ctrl.sv */
// Purpose: interrupt routing, polarity, global enable and WAIT/STOP sequencing
// Assumes: one clock pclk; pins are asynchronous and pass three flip-flops
// Notes: option register is write-only and reads as zero
//
// Overview of operation
// R1: Option register write-only, no bit access
// R2: Option register clears to zero on reset
// R3: Option bits 7 and 3..0 ignored
// R4: Level select makes source 1 level sensitive
// R5: Edge polarity select picks source 2 edge
// R6: Global enable gates all maskable sources
// R7: NMI serviced but no wake when disabled
// R8: Four masked peripheral events feed source 4
// R9: Three masked reload timer events feed source 3
// R10: Polarity register readable, writable, cleared by reset
// R11: Polarity bits 3, 1, 0 invert D, A, B
// R12: Ports B and D edges feed source 2
// R13: Port A edge or level feeds source 1
// R14: WAIT halts core, clock keeps running
// R15: WAIT exit resumes without settling delay
// R16: Reset during WAIT ends it normally
// R17: STOP only without watchdog, stops oscillator
// R18: STOP exit waits for oscillator settling
// R19: Pin reset during STOP ends it
// R20: Edge latch set once, cleared on service
// R21: Sleep skipped when enabled request pending
// R22: STOP acts as WAIT under watchdog
// R23: Waking interrupt serviced before resuming
// R24: Settling delay is a cycle count parameter
// R25: Option held internally, read returns zero
`timescale 1ns/1ns

module iosc_ctrl
    import iosc_pkg::*;
#(
    parameter int unsigned PORT_W = 8,
    parameter int unsigned STAB_CYCLES = IOSC_STAB_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire iosc_apb_req_t apb_req,
    output iosc_apb_rsp_t apb_rsp,
    input wire logic [PORT_W-1:0] port_a_pin,
    input wire logic [PORT_W-1:0] port_b_pin,
    input wire logic [PORT_W-1:0] port_d_pin,
    input wire logic [PORT_W-1:0] port_a_irq_en,
    input wire logic [PORT_W-1:0] port_b_irq_en,
    input wire logic [PORT_W-1:0] port_d_irq_en,
    input wire logic nmi_pin_n,
    input wire iosc_evt_t periph_evt,
    input wire iosc_mask_t periph_mask,
    input wire iosc_core_t core_in,
    output logic [4:0] irq_req,
    output logic core_halt,
    output logic osc_stop,
    output logic sleep_skip,
    output logic wake_pulse
);

    localparam int unsigned PW = 3 * PORT_W + 1;
    localparam int unsigned CW = $clog2(STAB_CYCLES + 1);
    localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);

    // Whole state of the block in one record
    typedef struct packed {
        logic [PW-1:0] sync1;
        logic [PW-1:0] sync2;
        logic [PW-1:0] sync3;
        logic [PW-1:0] filt;
        logic [PORT_W-1:0] act_a;
        logic [PORT_W-1:0] act_b;
        logic [PORT_W-1:0] act_d;
        logic nmi_prev;
        logic [2:0] fill;
        logic nmi_lat;
        logic lat1;
        logic lat2;
        logic [7:0] opt;
        logic [7:0] pol;
        iosc_sleep_t sleep;
        logic [CW-1:0] cnt;
        logic [4:0] irq;
        logic halt;
        logic ostop;
        logic skip;
        logic wake;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } iosc_state_t;

    iosc_state_t st_q; // Registered state
    iosc_state_t st_d; // Next state

    // Decoded controls and conditions
    logic gen; // Global enable
    logic level_edge_select; // Level select for source 1
    logic edge_polarity_select; // Edge polarity select
    logic inv_a; // Port A inversion
    logic inv_b; // Port B inversion
    logic inv_d; // Port D inversion
    logic [PORT_W-1:0] pa_f; // Filtered port A
    logic [PORT_W-1:0] pb_f; // Filtered port B
    logic [PORT_W-1:0] pd_f; // Filtered port D
    logic nmi_f; // Filtered NMI pin
    logic [PORT_W-1:0] act_a_n; // Port A active level
    logic [PORT_W-1:0] act_b_n; // Port B active level
    logic [PORT_W-1:0] act_d_n; // Port D active level
    logic edge_a; // Port A active edge
    logic edge_2; // Port B or D active edge
    logic nmi_edge; // NMI falling edge
    logic armed; // Sync pipe and edge history hold real pin values
    logic src1; // Source 1 raw request
    logic src2; // Source 2 raw request
    logic src3; // Source 3 raw request
    logic src4; // Source 4 raw request
    logic [4:0] req; // Requests offered to the core
    logic wake_any; // Wake condition in WAIT
    logic wake_ext; // Wake condition in STOP
    logic acc; // APB access phase
    logic wr_fire; // APB write completes
    logic rd_fire; // APB read answer loads
    logic hit_opt; // Option address
    logic hit_pol; // Polarity address
    logic hit_stat; // Status address

    // Field decode of the held option register
    assign gen = st_q.opt[IOSC_OPT_GEN_BIT];
    assign level_edge_select = st_q.opt[IOSC_OPT_LES_BIT];
    assign edge_polarity_select = st_q.opt[IOSC_OPT_ESB_BIT];

    // R11: polarity inverts ports
    assign inv_a = st_q.pol[IOSC_POL_A_BIT];
    // R12: rising when exactly one set
    assign inv_b = st_q.pol[IOSC_POL_B_BIT] ^ edge_polarity_select;
    assign inv_d = st_q.pol[IOSC_POL_D_BIT] ^ edge_polarity_select;

    // Filtered pin split
    assign pa_f = st_q.filt[PORT_W-1:0];
    assign pb_f = st_q.filt[2*PORT_W-1:PORT_W];
    assign pd_f = st_q.filt[3*PORT_W-1:2*PORT_W];
    assign nmi_f = st_q.filt[PW-1];

    // R13: active low unless inverted
    assign act_a_n = (pa_f ^ {PORT_W{~inv_a}}) & port_a_irq_en;
    // R5: source 2 polarity from select
    assign act_b_n = (pb_f ^ {PORT_W{~inv_b}}) & port_b_irq_en;
    assign act_d_n = (pd_f ^ {PORT_W{~inv_d}}) & port_d_irq_en;

    // Edges are ignored until the filter and history are filled, so reset
    // values never look like a pin edge
    assign armed = st_q.fill == 3'h5;
    // Edges from the gated active levels; a polarity change may look like an edge
    assign edge_a = armed & (|(act_a_n & ~st_q.act_a));
    assign edge_2 = armed & (|(act_b_n & ~st_q.act_b) | |(act_d_n & ~st_q.act_d));
    assign nmi_edge = armed & nmi_f & ~st_q.nmi_prev;

    // R4: level or latched edge
    assign src1 = level_edge_select ? |act_a_n : st_q.lat1;
    // R12: ports B and D on source 2
    assign src2 = st_q.lat2;
    // R9: reload timer events on source 3
    assign src3 = (periph_evt.reload_timer_overflow & periph_mask.reload_overflow_irq_mask)
        | (periph_evt.reload_timer_compare_hit & periph_mask.reload_compare_irq_mask)
        | (periph_evt.reload_timer_input_edge & periph_mask.reload_edge_irq_mask);
    // R8: peripheral events on source 4
    assign src4 = (periph_evt.timer_overflow_flag & periph_mask.timer_irq_mask)
        | (periph_evt.conversion_end & periph_mask.converter_irq_mask)
        | (periph_evt.serial_byte_received & periph_mask.serial_rx_irq_mask)
        | (periph_evt.serial_byte_sent & periph_mask.serial_tx_irq_mask);

    // R6: global enable gates maskables
    assign req = {gen & src4, gen & src3, gen & src2, gen & src1, st_q.nmi_lat};

    // R7: no wake without global enable
    assign wake_any = gen & (|req);
    // R17: only external sources wake STOP
    assign wake_ext = gen & (st_q.nmi_lat | src1 | src2);

    // APB decode; the answer comes one cycle into the access phase
    assign acc = apb_req.psel & apb_req.penable;
    assign wr_fire = acc & st_q.pready & apb_req.pwrite;
    assign rd_fire = acc & ~st_q.pready & ~apb_req.pwrite;
    assign hit_opt = apb_req.paddr == IOSC_OPT_ADDR;
    assign hit_pol = apb_req.paddr == IOSC_POL_ADDR;
    assign hit_stat = apb_req.paddr == IOSC_STAT_ADDR;

    // Next-state logic for the whole block
    always_comb begin
        st_d = st_q;

        // Three-stage pin synchronisers; a change counts once stages two and three agree
        st_d.sync1 = {~nmi_pin_n, port_d_pin, port_b_pin, port_a_pin};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int i = 0; i < PW; i++) begin
            if (st_q.sync2[i] == st_q.sync3[i]) begin
                st_d.filt[i] = st_q.sync3[i];
            end
        end
        // NMI kept active high inside; falling pin edge is a rising filt edge
        st_d.nmi_prev = nmi_f;
        // Count edges after reset until the pin history is trustworthy
        if (st_q.fill != 3'h5) begin
            st_d.fill = st_q.fill + 3'h1;
        end

        // Previous active levels for edge detection
        st_d.act_a = act_a_n;
        st_d.act_b = act_b_n;
        st_d.act_d = act_d_n;

        // R20: NMI latch, set wins over ack
        if (nmi_edge) begin
            st_d.nmi_lat = 1'b1;
        end else if (core_in.service_ack[IOSC_SRC_NMI]) begin
            st_d.nmi_lat = 1'b0;
        end
        // R20: source 1 edge latch
        if (edge_a & ~level_edge_select) begin
            st_d.lat1 = 1'b1;
        end else if (core_in.service_ack[IOSC_SRC_1] | level_edge_select) begin
            // Level mode stores nothing
            st_d.lat1 = 1'b0;
        end
        // R20: source 2 edge latch
        if (edge_2) begin
            st_d.lat2 = 1'b1;
        end else if (core_in.service_ack[IOSC_SRC_2]) begin
            st_d.lat2 = 1'b0;
        end

        // Request lines to the core, registered
        st_d.irq = req;

        // Default pulses
        st_d.skip = 1'b0;
        st_d.wake = 1'b0;

        // Sleep sequencer
        case (st_q.sleep)
            IOSC_RUN: begin
                if (core_in.wait_exec | core_in.stop_exec) begin
                    if (wake_any) begin
                        // R21: pending request skips sleep
                        st_d.skip = 1'b1;
                    end else if (core_in.stop_exec & ~core_in.watchdog_active) begin
                        // R17: STOP halts the oscillator
                        st_d.sleep = IOSC_STOP;
                    end else begin
                        // R22: STOP becomes WAIT
                        // R14: WAIT halts core only
                        st_d.sleep = IOSC_WAIT;
                    end
                end
            end
            IOSC_WAIT: begin
                if (wake_any) begin
                    // R15: resume with no delay
                    // R23: core services waking request
                    st_d.sleep = IOSC_RUN;
                    st_d.wake = 1'b1;
                end
            end
            IOSC_STOP: begin
                if (wake_ext) begin
                    // R18: settle before first instruction
                    st_d.sleep = IOSC_STAB;
                    st_d.cnt = '0;
                end
            end
            IOSC_STAB: begin
                // R24: settling count from parameter
                if (st_q.cnt == STAB_LAST) begin
                    st_d.sleep = IOSC_RUN;
                    st_d.wake = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt + CW'(1);
                end
            end
            default: begin
                // Illegal code falls back to running
                st_d.sleep = IOSC_RUN;
            end
        endcase

        // Halt and oscillator controls follow the next state
        st_d.halt = st_d.sleep != IOSC_RUN;
        st_d.ostop = st_d.sleep == IOSC_STOP;

        // APB ready pulse for one cycle of the access phase
        st_d.pready = acc & ~st_q.pready;
        if (acc & ~st_q.pready) begin
            st_d.pslverr = ~(hit_opt | hit_pol | hit_stat);
        end else begin
            st_d.pslverr = 1'b0;
        end

        // Read data; option reads zero
        if (rd_fire) begin
            // R25: option read returns zero
            if (hit_pol) begin
                // R10: polarity read back
                st_d.prdata = {24'h000000, st_q.pol};
            end else if (hit_stat) begin
                st_d.prdata = {19'h00000, st_q.irq, st_q.sleep, st_q.lat2, st_q.lat1,
                    st_q.nmi_lat, st_q.halt};
            end else begin
                st_d.prdata = 32'h00000000;
            end
        end

        // Writes take effect at the completing edge
        if (wr_fire & hit_opt) begin
            // R1: whole word write only
            // R3: unused bits dropped
            st_d.opt = apb_req.pwdata[7:0] & IOSC_OPT_USED;
        end
        if (wr_fire & hit_pol) begin
            // R11: only bits 3, 1, 0 kept
            st_d.pol = apb_req.pwdata[7:0] & IOSC_POL_USED;
        end
    end

    // State register; reset also ends any sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            // R2: option clears on reset
            st_q.opt <= IOSC_OPT_RST;
            // R10: polarity clears on reset
            st_q.pol <= IOSC_POL_RST;
            // R16: reset leaves WAIT
            // R19: reset leaves STOP
            st_q.sleep <= IOSC_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp.prdata = st_q.prdata;
    assign apb_rsp.pready = st_q.pready;
    assign apb_rsp.pslverr = st_q.pslverr;
    assign irq_req = st_q.irq;
    assign core_halt = st_q.halt;
    assign osc_stop = st_q.ostop;
    assign sleep_skip = st_q.skip;
    assign wake_pulse = st_q.wake;

endmodule

/* File: test/iosc_ctrl_asserts.sv */
// Purpose: port-level assertions for the interrupt option and sleep control
// Assumes: single pclk domain, presetn async active low
// Notes: global enable is shadowed from completed option writes
`timescale 1ns/1ns
module iosc_ctrl_asserts
    import iosc_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = IOSC_STAB_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire iosc_apb_req_t apb_req,
    input wire iosc_apb_rsp_t apb_rsp,
    input wire iosc_evt_t periph_evt,
    input wire iosc_mask_t periph_mask,
    input wire iosc_core_t core_in,
    input wire logic [4:0] irq_req,
    input wire logic core_halt,
    input wire logic osc_stop,
    input wire logic sleep_skip,
    input wire logic wake_pulse
);
    logic gen_q; // Shadow of the write-only enable
    logic stab_q; // Settling after an oscillator stop
    logic [15:0] cnt_q; // Cycles spent settling
    logic [6:0] hit; // Masked events
    logic wr_opt;
    logic slp;
    assign hit = periph_evt & periph_mask;
    assign slp = (core_in.wait_exec || core_in.stop_exec) && !core_halt;
    assign wr_opt = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
        && apb_req.paddr == IOSC_OPT_ADDR;
    // Shadow state, reset alongside the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q <= 1'b0;
            stab_q <= 1'b0;
            cnt_q <= 16'h0000;
        end else begin
            if (wr_opt) begin
                gen_q <= apb_req.pwdata[IOSC_OPT_GEN_BIT];
            end
            stab_q <= osc_stop || (stab_q && core_halt);
            cnt_q <= (osc_stop || !core_halt) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_opt_reads_zero: assert property (apb_rsp.pready && !apb_req.pwrite
        && apb_req.paddr == IOSC_OPT_ADDR |-> apb_rsp.prdata == 32'h0) else $error("option read nonzero");
    chk_gen_blocks: assert property (!gen_q && !$past(gen_q) |-> irq_req[4:1] == 4'h0)
        else $error("maskable request while disabled");
    chk_src4_or: assert property (gen_q && $past(gen_q) |-> irq_req[4] == $past(|hit[6:3]))
        else $error("source 4 mismatch");
    chk_src3_or: assert property (gen_q && $past(gen_q) |-> irq_req[3] == $past(|hit[2:0]))
        else $error("source 3 mismatch");
    chk_sleep_entry: assert property (slp |=> core_halt != sleep_skip)
        else $error("sleep neither entered nor skipped");
    chk_skip_pending: assert property (slp && gen_q && (|irq_req) |=> sleep_skip)
        else $error("sleep not skipped with pending request");
    chk_stop_wdg: assert property (slp && core_in.stop_exec && core_in.watchdog_active
        |=> !osc_stop) else $error("oscillator stopped under watchdog");
    chk_stop_osc: assert property (slp && core_in.stop_exec |=> osc_stop ==
        (core_halt && !core_in.watchdog_active)) else $error("stop state mismatch");
    chk_stab_len: assert property (stab_q && !osc_stop |->
        (cnt_q == STAB_CYCLES) == (wake_pulse && !core_halt)) else $error("settling length wrong");
    chk_no_wake_off: assert property (core_halt && !gen_q |=> core_halt)
        else $error("wake while disabled");
    chk_wait_exit: assert property (core_halt && !osc_stop && !stab_q && gen_q && (|irq_req)
        |=> wake_pulse && !core_halt) else $error("wait exit delayed");
    cover property (wake_pulse && stab_q);
    cover property (sleep_skip);
    cover property (core_halt && !gen_q && irq_req[0]);
endmodule
bind iosc_ctrl iosc_ctrl_asserts #(.STAB_CYCLES(STAB_CYCLES)) chk_u (.pclk, .presetn, .apb_req,
    .apb_rsp, .periph_evt, .periph_mask, .core_in, .irq_req, .core_halt, .osc_stop, .sleep_skip,
    .wake_pulse);

/* File: test/iosc_core_model.sv */
// Purpose: processor core model issuing sleep instructions and routine starts
// Assumes: commands from the bench, one pclk domain
// Notes: acks the highest priority request, then pauses three cycles
`timescale 1ns/1ns
module iosc_core_model
    import iosc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] irq_req,
    input wire logic core_halt,
    input wire logic ack_en,
    input wire logic [1:0] sleep_cmd,
    input wire logic wdg_on,
    output iosc_core_t core_in
);
    logic [1:0] hold_q; // Gap between routine starts
    // A halted core executes nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_in <= '0;
            hold_q <= 2'h0;
        end else begin
            core_in.wait_exec <= sleep_cmd[0] && !core_halt;
            core_in.stop_exec <= sleep_cmd[1] && !core_halt;
            core_in.watchdog_active <= wdg_on;
            core_in.service_ack <= 5'h00;
            if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
            // Routine start, lowest index wins
            if (ack_en && !core_halt && hold_q == 2'h0 && irq_req != 5'h00) begin
                core_in.service_ack <= irq_req & (~irq_req + 5'h01);
                hold_q <= 2'h3;
            end
        end
    end
endmodule

/* File: test/test_interrupt_option_and_sleep_control.sv */
// Purpose: self-checking bench for the interrupt option and sleep control
// Assumes: settling count shortened to 4 cycles
// Notes: port D pins tied idle, port D interrupts disabled
`timescale 1ns/1ns
module test_interrupt_option_and_sleep_control
    import iosc_pkg::*;
;
    // Rows: events, masks, expected sources 4 and 3
    localparam logic [15:0] TAB [9] = '{{7'h40, 7'h40, 2'h2}, {7'h40, 7'h3F, 2'h0},
        {7'h20, 7'h20, 2'h2}, {7'h10, 7'h10, 2'h2}, {7'h08, 7'h08, 2'h2}, {7'h04, 7'h04, 2'h1},
        {7'h02, 7'h02, 2'h1}, {7'h01, 7'h01, 2'h1}, {7'h7F, 7'h44, 2'h3}};
    logic pclk, presetn, nmi_n, halt, oscs, skip, wake, ack_en, wdg, err;
    iosc_apb_req_t req;
    iosc_apb_rsp_t rsp;
    iosc_evt_t evt;
    iosc_mask_t msk;
    iosc_core_t core;
    logic [7:0] pa, pb, a_en, b_en;
    logic [4:0] irq;
    logic [1:0] slp;
    logic [31:0] rd;
    int bad_count, checked, cyc, i;
    iosc_ctrl #(.PORT_W(8), .STAB_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .port_a_pin(pa), .port_b_pin(pb), .port_d_pin(8'hFF),
        .port_a_irq_en(a_en), .port_b_irq_en(b_en), .port_d_irq_en(8'h00), .nmi_pin_n(nmi_n),
        .periph_evt(evt), .periph_mask(msk), .core_in(core), .irq_req(irq), .core_halt(halt),
        .osc_stop(oscs), .sleep_skip(skip), .wake_pulse(wake));
    iosc_core_model core_u (.pclk(pclk), .presetn(presetn), .irq_req(irq), .core_halt(halt),
        .ack_en(ack_en), .sleep_cmd(slp), .wdg_on(wdg), .core_in(core));
    task results;
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    // One APB transfer, held until pready is seen
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= {24'h000000, d};
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        // Sample pready at each rising edge; data taken at that same edge
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        if (n >= 20) bad_count++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task ack;
        ack_en <= 1'b1;
        step(4);
        ack_en <= 1'b0;
        step(2);
    endtask
    task sleep(input logic [1:0] c);
        slp <= c;
        step(1);
        slp <= 2'h0;
        step(3);
    endtask
    // Bounded wait for a pulse, ends at a falling edge
    task automatic wait_hi(input string nm, ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        chk(nm, 1, 32'(s));
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        {pa, pb, a_en, b_en} = 32'hFFFF0101;
        {nmi_n, ack_en, wdg, slp, evt, msk} = 19'h40000;
        {bad_count, checked, cyc} = '0;
        step(10);
        presetn <= 1'b1;
        step(2);
        apb(0, IOSC_OPT_ADDR, 8'h00);
        chk("opt_reset", 0, rd);
        apb(0, IOSC_POL_ADDR, 8'h00);
        chk("pol_reset", 0, rd);
        apb(1, IOSC_POL_ADDR, 8'hFF);
        apb(0, IOSC_POL_ADDR, 8'h00);
        chk("pol_rw", 32'h0B, rd);
        apb(0, 12'h100, 8'h00);
        chk("unmapped", 1, 32'(err));
        apb(1, IOSC_OPT_ADDR, 8'hFF);
        apb(0, IOSC_OPT_ADDR, 8'h00);
        chk("opt_wo", 0, rd);
        apb(1, IOSC_POL_ADDR, 8'h00);
        apb(1, IOSC_OPT_ADDR, 8'h8F);
        msk <= 7'h7F;
        evt <= 7'h40;
        step(4);
        chk("gen_unused", 0, 32'(irq));
        apb(1, IOSC_OPT_ADDR, 8'h10);
        for (i = 0; i < 9; i++) begin
            evt <= TAB[i][15:9];
            msk <= TAB[i][8:2];
            step(3);
            chk("src4_src3", 32'(TAB[i][1:0]), 32'(irq[4:3]));
        end
        evt <= '0;
        pa[0] <= 1'b0;
        step(8);
        chk("src1_fall", 1, 32'(irq[1]));
        ack();
        chk("src1_ack", 0, 32'(irq[1]));
        apb(1, IOSC_OPT_ADDR, 8'h50);
        step(3);
        chk("src1_level", 1, 32'(irq[1]));
        pa[0] <= 1'b1;
        step(8);
        chk("src1_high", 0, 32'(irq[1]));
        for (i = 0; i < 4; i++) begin
            apb(1, IOSC_POL_ADDR, {7'h00, i[0]});
            apb(1, IOSC_OPT_ADDR, {2'h0, i[1], 5'h10});
            pb[0] <= ~(i[0] ^ i[1]);
            step(8);
            ack();
            chk("src2_quiet", 0, 32'(irq[2]));
            pb[0] <= i[0] ^ i[1];
            step(8);
            chk("src2_edge", 1, 32'(irq[2]));
            ack();
        end
        apb(1, IOSC_POL_ADDR, 8'h00);
        ack();
        sleep(2'h1);
        chk("wait_halt", 1, 32'(halt));
        chk("wait_osc", 0, 32'(oscs));
        evt <= 7'h40;
        wait_hi("wait_wake", wake);
        step(1);
        // Skip is a one-cycle pulse, so watch for it straight after the command is issued
        slp <= 2'h1;
        step(1);
        slp <= 2'h0;
        wait_hi("skip", skip);
        chk("skip_run", 0, 32'(halt));
        step(3);
        step(1);
        evt <= '0;
        wdg <= 1'b1;
        step(2);
        sleep(2'h2);
        chk("wdg_halt", 1, 32'(halt));
        chk("wdg_osc", 0, 32'(oscs));
        evt <= 7'h40;
        wait_hi("wdg_wake", wake);
        step(1);
        evt <= '0;
        wdg <= 1'b0;
        step(2);
        sleep(2'h2);
        chk("stop_osc", 1, 32'(oscs));
        evt <= 7'h40;
        step(8);
        chk("stop_hold", 1, 32'(halt));
        nmi_n <= 1'b0;
        wait_hi("stop_wake", wake);
        chk("stop_osc_off", 0, 32'(oscs));
        step(1);
        evt <= '0;
        nmi_n <= 1'b1;
        ack();
        apb(1, IOSC_OPT_ADDR, 8'h00);
        sleep(2'h1);
        nmi_n <= 1'b0;
        step(10);
        chk("nmi_seen", 1, 32'(irq[0]));
        chk("nmi_no_wake", 1, 32'(halt));
        presetn <= 1'b0;
        step(2);
        presetn <= 1'b1;
        step(2);
        chk("reset_run", 0, 32'(halt));
        results();
    end
endmodule
